// [spr_pkg.sv]
package spr_pkg;

	// ----------------------------------------------------------------
	// register byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL0 = 8'h00;
	localparam logic [7:0] OFS_CTRL1 = 8'h04;
	localparam logic [7:0] OFS_DATA = 8'h08;
	localparam logic [7:0] OFS_STATUS = 8'h0c;
	localparam logic [7:0] OFS_PRESCALE = 8'h10;
	localparam logic [7:0] OFS_IMASK = 8'h14;
	localparam logic [7:0] OFS_RAW = 8'h18;
	localparam logic [7:0] OFS_MASKED = 8'h1c;
	localparam logic [7:0] OFS_ICLEAR = 8'h20;
	localparam logic [7:0] OFS_DMA = 8'h24;
	localparam logic [7:0] OFS_RECEIVE_FRAME_COUNT_CNT = 8'h28;
	localparam logic [7:0] OFS_DUMMY = 8'h2c;
	localparam logic [7:0] OFS_TXQ_CNT = 8'h30;
	localparam logic [7:0] OFS_ITEST = 8'h80;
	localparam logic [7:0] OFS_TDATA = 8'h8c;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [31:0] RST_CTRL0 = 32'h1c000000;
	localparam logic [31:0] RST_STATUS = 32'h00000003;
	localparam logic [31:0] RST_ZERO = 32'h00000000;

	// ----------------------------------------------------------------
	// control word zero fields
	// ----------------------------------------------------------------
	localparam int LEN_LSB = 0;
	localparam int POL_BIT = 6;
	localparam int PHA_BIT = 7;
	localparam int RATE_LSB = 8;
	localparam int FMT_LSB = 21;
	localparam logic [4:0] LEN_MIN = 5'h03;
	localparam logic [1:0] FMT_STD = 2'h0;
	localparam logic [1:0] FMT_CMD = 2'h2;

	// control word one: enable bit
	localparam int EN_BIT = 1;

	// status bits: 0 tx queue empty, 1 tx queue not full, 4 busy
	localparam int ST_TXE = 0;
	localparam int ST_TNF = 1;
	localparam int ST_BSY = 4;

	// interrupt bit: frame done
	localparam int IRQ_DONE = 0;
	localparam int IRQ_W = 4;

	// prescale divisor limits
	localparam logic [7:0] PRE_MIN = 8'h02;

	// ----------------------------------------------------------------
	// bus request carrier
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [7:0] addr;
		logic write;
		logic valid;
	} spr_req_s;

	typedef enum logic [1:0] {
		SPR_IDLE,
		SPR_LEAD,
		SPR_TRAIL
	} spr_state_e;

endpackage

// [spr_ctrl.sv]
// Our own choice: the AHB-Lite register port.
`timescale 1ns/100ps
// How it works
// - frame length is the length field plus one, fields below three treated as four bits.
// - the idle polarity bit sets the rest level of the serial clock in standard format.
// - the phase bit chooses the sampling edge, used only in standard format.
// - bit rate is the bus clock over prescale divisor times one plus rate field.
// - the rate field is bits fifteen to eight and takes any value up to 255.
// - the prescale register at 0x10 holds the even divisor and resets to zero.
// - the receive frame count at 0x28 is read-write and counts frames still to receive.
// - the transmit queue frame count at 0x30 is read-write and resets to zero.
// - the interrupt clear register at 0x20 is write-only and clears latched events.
// - raw status at 0x18 and masked status at 0x1c are read-only, masked by 0x14.
// - the status register at 0x0c resets to 0x00000003.
// - control word zero resets to 0x1c000000, status to 0x00000003, other registers to zero.
// - the DMA control register at 0x24 is read-write.
// - format field 0 is standard four-wire, 2 is three-wire with polarity and phase ignored.
module spr_ctrl (
	// bus clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// serial pins
	output logic sclk,
	output logic mosi,
	output logic cs_n,
	input wire logic miso,
	// interrupt
	output logic irq
);

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	logic [31:0] ctrl0_reg, ctrl1_reg, data_reg, pre_reg, imask_reg;
	logic [31:0] dma_reg, rxcnt_reg, dummy_reg, txcnt_reg, itest_reg, tdata_reg;
	localparam int IRQ_W_L = spr_pkg::IRQ_W;
	logic [IRQ_W_L-1:0] raw_reg;
	spr_pkg::spr_req_s req_reg;
	logic [31:0] rdata_reg;
	logic irq_reg;
	// serial engine
	spr_pkg::spr_state_e st_reg;
	logic [7:0] pre_cnt_reg, rate_cnt_reg;
	logic [5:0] bit_cnt_reg;
	logic [31:0] sh_reg;
	logic sclk_reg, mosi_reg, cs_n_reg, txfull_reg, busy_reg;
	logic [2:0] miso_sync_reg;
	logic miso_s_reg;

	// ----------------------------------------------------------------
	// field decode
	// ----------------------------------------------------------------
	// frame length; reserved codes are clamped so the engine never hangs
	// length plus one
	wire [4:0] len_fld = ctrl0_reg[spr_pkg::LEN_LSB +: 5];
	wire [4:0] len_eff = (len_fld < spr_pkg::LEN_MIN) ? spr_pkg::LEN_MIN : len_fld;
	wire std_fmt = ctrl0_reg[spr_pkg::FMT_LSB +: 2] != spr_pkg::FMT_CMD;
	wire pol = std_fmt & ctrl0_reg[spr_pkg::POL_BIT];
	wire pha = std_fmt & ctrl0_reg[spr_pkg::PHA_BIT];
	wire [7:0] rate = ctrl0_reg[spr_pkg::RATE_LSB +: 8];
	// prescale divisor, forced even and at least two
	wire [7:0] pre_raw = {pre_reg[7:1], 1'b0};
	wire [7:0] pre_div = (pre_raw < spr_pkg::PRE_MIN) ? spr_pkg::PRE_MIN : pre_raw;
	wire enable = ctrl1_reg[spr_pkg::EN_BIT];

	// ----------------------------------------------------------------
	// bus decode
	// ----------------------------------------------------------------
	wire take = hsel & hready & htrans[1];
	wire wr = req_reg.valid & req_reg.write;
	function automatic logic hit(input logic [7:0] ofs);
		hit = wr && (req_reg.addr == ofs);
	endfunction
	wire wr_data = hit(spr_pkg::OFS_DATA);
	wire [IRQ_W_L-1:0] clr = hit(spr_pkg::OFS_ICLEAR) ? hwdata[IRQ_W_L-1:0] : '0;
	wire [31:0] raw32 = {28'h0000000, raw_reg};
	wire [31:0] masked32 = raw32 & imask_reg;
	wire [31:0] status32 = {27'h0000000, busy_reg, 2'b00, ~txfull_reg, ~txfull_reg};
	wire [7:0] ra = haddr[7:0];
	wire [31:0] rd_mux =
		(ra == spr_pkg::OFS_CTRL0) ? ctrl0_reg :
		(ra == spr_pkg::OFS_CTRL1) ? ctrl1_reg :
		(ra == spr_pkg::OFS_DATA) ? data_reg :
		(ra == spr_pkg::OFS_STATUS) ? status32 :
		(ra == spr_pkg::OFS_PRESCALE) ? pre_reg :
		(ra == spr_pkg::OFS_IMASK) ? imask_reg :
		(ra == spr_pkg::OFS_RAW) ? raw32 :
		(ra == spr_pkg::OFS_MASKED) ? masked32 :
		(ra == spr_pkg::OFS_DMA) ? dma_reg :
		(ra == spr_pkg::OFS_RECEIVE_FRAME_COUNT_CNT) ? rxcnt_reg :
		(ra == spr_pkg::OFS_DUMMY) ? dummy_reg :
		(ra == spr_pkg::OFS_TXQ_CNT) ? txcnt_reg :
		(ra == spr_pkg::OFS_ITEST) ? itest_reg :
		(ra == spr_pkg::OFS_TDATA) ? tdata_reg : 32'h00000000;

	// address phase capture and read data, zero wait states
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			req_reg <= '0;
			rdata_reg <= 32'h00000000;
		end else begin
			req_reg <= '{addr: haddr[7:0], write: hwrite, valid: take};
			if (take && !hwrite) begin
				rdata_reg <= rd_mux;
			end
		end
	end

	// ----------------------------------------------------------------
	// register writes
	// ----------------------------------------------------------------
	// reset values
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl0_reg <= spr_pkg::RST_CTRL0;
			ctrl1_reg <= spr_pkg::RST_ZERO;
			pre_reg <= spr_pkg::RST_ZERO;
			imask_reg <= spr_pkg::RST_ZERO;
			dma_reg <= spr_pkg::RST_ZERO;
			dummy_reg <= spr_pkg::RST_ZERO;
			itest_reg <= spr_pkg::RST_ZERO;
			tdata_reg <= spr_pkg::RST_ZERO;
		end else begin
			if (hit(spr_pkg::OFS_CTRL0)) ctrl0_reg <= hwdata;
			if (hit(spr_pkg::OFS_CTRL1)) ctrl1_reg <= hwdata;
			if (hit(spr_pkg::OFS_PRESCALE)) pre_reg <= hwdata;
			if (hit(spr_pkg::OFS_IMASK)) imask_reg <= hwdata;
			if (hit(spr_pkg::OFS_DMA)) dma_reg <= hwdata;
			if (hit(spr_pkg::OFS_DUMMY)) dummy_reg <= hwdata;
			if (hit(spr_pkg::OFS_ITEST)) itest_reg <= hwdata;
			if (hit(spr_pkg::OFS_TDATA)) tdata_reg <= hwdata;
		end
	end

	// ----------------------------------------------------------------
	// serial engine
	// ----------------------------------------------------------------
	// one-cycle half-bit tick: prescale times (1 + rate) bus cycles per bit
	wire pre_tick = (pre_cnt_reg == 8'h00);
	wire half_tick = pre_tick & (rate_cnt_reg == 8'h00);
	wire half_load = pre_tick & (rate_cnt_reg == 8'h00);
	wire [7:0] pre_half = {1'b0, pre_div[7:1]};
	// dummy character is sent when the queue is empty and frames are owed
	wire use_dummy = ~txfull_reg & (rxcnt_reg != 32'h0);
	// select must rest high a cycle between frames so the slave sees each one
	wire start = enable & (txfull_reg | use_dummy) & cs_n_reg & (st_reg == spr_pkg::SPR_IDLE);
	wire last_bit = (bit_cnt_reg == 6'd0);
	wire [5:0] len_bits = {1'b0, len_eff};
	// word that goes out: queued data or the dummy character
	wire [31:0] tx_word = use_dummy ? dummy_reg : data_reg;

	// miso passes three flops; a change counts when the last two agree
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			miso_sync_reg <= 3'b000;
			miso_s_reg <= 1'b0;
		end else begin
			miso_sync_reg <= {miso_sync_reg[1:0], miso};
			if (miso_sync_reg[2] == miso_sync_reg[1]) miso_s_reg <= miso_sync_reg[2];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pre_cnt_reg <= 8'h00;
			rate_cnt_reg <= 8'h00;
		end else if (st_reg == spr_pkg::SPR_IDLE) begin
			pre_cnt_reg <= pre_half - 8'h01;
			rate_cnt_reg <= rate;
		end else if (pre_tick) begin
			pre_cnt_reg <= pre_half - 8'h01;
			rate_cnt_reg <= half_load ? rate : rate_cnt_reg - 8'h01;
		end else begin
			pre_cnt_reg <= pre_cnt_reg - 8'h01;
		end
	end

	// frame sequencer: lead edge then trail edge per bit, msb first
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_reg <= spr_pkg::SPR_IDLE;
			bit_cnt_reg <= 6'd0;
			sh_reg <= 32'h00000000;
			sclk_reg <= 1'b0;
			mosi_reg <= 1'b0;
			cs_n_reg <= 1'b1;
			busy_reg <= 1'b0;
		end else begin
			case (st_reg)
				spr_pkg::SPR_IDLE: begin
					sclk_reg <= pol;
					busy_reg <= 1'b0;
					cs_n_reg <= 1'b1;
					if (start) begin
						sh_reg <= tx_word << (6'd31 - len_bits);
						mosi_reg <= tx_word[len_eff];
						bit_cnt_reg <= len_bits;
						cs_n_reg <= 1'b0;
						busy_reg <= 1'b1;
						st_reg <= spr_pkg::SPR_LEAD;
					end
				end
				spr_pkg::SPR_LEAD: if (half_tick) begin
					sclk_reg <= ~sclk_reg;
					// phase zero samples on leading edge
					if (!pha) sh_reg <= {sh_reg[30:0], miso_s_reg};
					// phase one launches each bit on the leading edge, clear of sampling
					if (pha) mosi_reg <= sh_reg[31];
					st_reg <= spr_pkg::SPR_TRAIL;
				end
				spr_pkg::SPR_TRAIL: if (half_tick) begin
					sclk_reg <= ~sclk_reg;
					// phase one samples on trailing edge
					if (pha) sh_reg <= {sh_reg[30:0], miso_s_reg};
					if (last_bit) begin
						st_reg <= spr_pkg::SPR_IDLE;
					end else begin
						bit_cnt_reg <= bit_cnt_reg - 6'd1;
						// phase zero launches the next bit on the trailing edge
						if (!pha) mosi_reg <= sh_reg[31];
						st_reg <= spr_pkg::SPR_LEAD;
					end
				end
				default: st_reg <= spr_pkg::SPR_IDLE;
			endcase
		end
	end

	wire frame_end = (st_reg == spr_pkg::SPR_TRAIL) & half_tick & last_bit;

	// data word: written by software, replaced by received frame
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			data_reg <= spr_pkg::RST_ZERO;
			txfull_reg <= 1'b0;
		end else begin
			if (wr_data) begin
				data_reg <= hwdata;
				txfull_reg <= 1'b1;
			end else if (start && !use_dummy) begin
				txfull_reg <= 1'b0;
			end
			if (frame_end) data_reg <= pha ? {sh_reg[30:0], miso_s_reg} : sh_reg;
		end
	end

	// frame counters: receive count decremented before each dummy frame goes out, queue count before each data frame while non-zero
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rxcnt_reg <= spr_pkg::RST_ZERO;
			txcnt_reg <= spr_pkg::RST_ZERO;
		end else begin
			if (hit(spr_pkg::OFS_RECEIVE_FRAME_COUNT_CNT)) rxcnt_reg <= hwdata;
			else if (start && use_dummy) rxcnt_reg <= rxcnt_reg - 32'h1;
			if (hit(spr_pkg::OFS_TXQ_CNT)) txcnt_reg <= hwdata;
			else if (start && !use_dummy && txcnt_reg != 32'h0) txcnt_reg <= txcnt_reg - 32'h1;
		end
	end

	// ----------------------------------------------------------------
	// interrupts
	// ----------------------------------------------------------------
	// write one clears, a new event wins over the clear
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			raw_reg <= '0;
			irq_reg <= 1'b0;
		end else begin
			raw_reg <= (raw_reg & ~clr) | {{(IRQ_W_L-1){1'b0}}, frame_end};
			irq_reg <= |(((raw_reg & ~clr) | {{(IRQ_W_L-1){1'b0}}, frame_end})
				& imask_reg[IRQ_W_L-1:0]);
		end
	end

	// outputs straight from flops, except ready and response, which are tied off
	assign hrdata = rdata_reg;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign sclk = sclk_reg;
	assign mosi = mosi_reg;
	assign cs_n = cs_n_reg;
	assign irq = irq_reg;

endmodule

// [spr_chk.sv]
`timescale 1ns/100ps
// ------------------------------------------------
// port checker
// ------------------------------------------------
module spr_chk (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// bus side
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	// serial side
	input wire logic sclk,
	input wire logic mosi,
	input wire logic cs_n,
	input wire logic irq
);
	logic rd_reg, bad_reg, sclk_reg, cs_reg;
	logic [7:0] tgl_reg;
	logic [7:0] tgl_next;
	wire take_rd = hsel && hready && htrans[1] && !hwrite;
	wire unmapped = haddr[7:0] > 8'h30 && haddr[7:0] != 8'h80 && haddr[7:0] != 8'h8c;
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// toggles since select fell; restarts at every frame, even back to back
	assign tgl_next = cs_reg ? 8'h00 : tgl_reg + {7'h0, sclk != sclk_reg};
	// last-cycle copies
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rd_reg <= 1'b0;
			bad_reg <= 1'b0;
			sclk_reg <= 1'b0;
			cs_reg <= 1'b1;
			tgl_reg <= 8'h00;
		end else begin
			rd_reg <= take_rd;
			bad_reg <= take_rd && unmapped;
			sclk_reg <= sclk;
			cs_reg <= cs_n;
			tgl_reg <= tgl_next;
		end
	end
	chk_reset_quiet: assert property (disable iff (1'b0)
		!hresetn |-> cs_n && !sclk && !irq && hrdata == 32'h0)
		else $error("outputs not quiet in reset");
	chk_bus_okay: assert property (hreadyout && !hresp)
		else $error("bus not ready or not okay");
	chk_unmapped_zero: assert property (bad_reg |-> hrdata == 32'h0)
		else $error("unmapped read not zero");
	chk_rdata_hold: assert property ($changed(hrdata) |-> rd_reg)
		else $error("read data moved without a read");
	chk_frame_toggles: assert property ((!cs_reg && cs_n) |->
		!tgl_next[0] && tgl_next >= 8'h08 && tgl_next <= 8'h40)
		else $error("frame toggle count out of range");
	chk_frame_min: assert property ($fell(cs_n) |=> !cs_n [*6])
		else $error("frame shorter than eight edges");
	chk_mosi_edge: assert property ((!cs_n && !cs_reg && $changed(mosi)) |->
		sclk != sclk_reg)
		else $error("data moved off a clock edge");
	chk_irq_after: assert property ($rose(irq) |=> cs_n)
		else $error("interrupt rose inside a frame");
endmodule

// [spr_slave.sv]
`timescale 1ns/100ps
// ------------------------------------------------
// far-side serial slave model
// ------------------------------------------------
module spr_slave #(
	parameter logic [31:0] REPLY = 32'h96c3a51e
) (
	// serial pins
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic mosi,
	output logic miso,
	// frame setup and capture
	input wire logic pol,
	input wire logic pha,
	input wire logic [5:0] len,
	output logic [31:0] got,
	output logic [5:0] nbits
);
	logic [31:0] tx;
	initial miso = 1'b0;
	// load reply at select; phase zero needs the first bit before any edge
	always @(negedge cs_n) begin
		got = 32'h0;
		nbits = 6'h0;
		tx = REPLY << (6'h20 - len);
		if (!pha) begin
			miso = tx[31];
			tx = tx << 1;
		end
	end
	always @(sclk) begin
		if (!cs_n && ((sclk != pol) ^ pha)) begin
			got = {got[30:0], mosi};
			nbits = nbits + 6'h1;
		end else if (!cs_n) begin
			miso = tx[31];
			tx = tx << 1;
		end
	end
	// released line shows the inverse of its last level
	always @(posedge cs_n) miso = ~miso;
endmodule

// [tb_spr_ctrl.sv]
`timescale 1ns/100ps
// ------------------------------------------------
// bench for the serial controller
// ------------------------------------------------
module tb_spr_ctrl;
	localparam logic [31:0] REPLY = 32'h5a3c96e1;
	logic hclk = 1'b0;
	logic hresetn = 1'b1;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata, got, q, r;
	logic hreadyout, hresp, sclk, mosi, cs_n, miso, irq;
	logic pol = 1'b0;
	logic pha = 1'b0;
	logic [5:0] len = 6'h4;
	logic [5:0] nbits;
	int num_errors = 0;
	int cmp_count = 0;
	int cyc = 0;
	always #4 hclk = ~hclk;
	spr_ctrl dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .sclk(sclk), .mosi(mosi), .cs_n(cs_n),
		.miso(miso), .irq(irq));
	spr_slave #(.REPLY(REPLY)) far (.sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso),
		.pol(pol), .pha(pha), .len(len), .got(got), .nbits(nbits));
	task automatic close_out;
		$display("errors %0d of %0d compares", num_errors, cmp_count);
		if (num_errors == 0 && cmp_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		cmp_count++;
		if (seen !== want) begin
			num_errors++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, want);
		end
	endtask
	// one word transfer; each phase held until ready is seen
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] want);
		bus(1'b0, a, 32'h0);
		check(q, want);
	endtask
	task automatic wait_irq;
		for (int n = 0; n < 4000 && irq !== 1'b1; n++) @(posedge hclk);
	endtask
	// one frame: edge spacing, bits sent and bits returned
	task automatic frame(input logic [7:0] pre, input logic [7:0] rate, input logic [31:0] d);
		int first, last;
		logic ls, lc;
		logic [31:0] m;
		first = -1;
		last = 0;
		m = 32'hffffffff >> (6'h20 - len);
		bus(1'b1, spr_pkg::OFS_PRESCALE, {24'h0, pre});
		bus(1'b1, spr_pkg::OFS_CTRL0, {16'h0, rate, pha, pol, 1'b0, len[4:0] - 5'h1});
		bus(1'b1, spr_pkg::OFS_ICLEAR, 32'h1);
		check({31'h0, sclk}, {31'h0, pol});
		ls = sclk;
		lc = 1'b1;
		bus(1'b1, spr_pkg::OFS_DATA, d);
		for (int n = 0; n < 4000 && irq !== 1'b1; n++) begin
			@(negedge hclk); // mid-cycle, clear of the launching edge
			if ((!cs_n || !lc) && sclk !== ls) begin
				if (first < 0) first = n;
				last = n;
			end
			ls = sclk;
			lc = cs_n;
		end
		check(last - first, (2 * len - 1) * (pre / 2) * (rate + 1));
		check({26'h0, nbits}, {26'h0, len});
		check(got & m, d & m);
		bus(1'b0, spr_pkg::OFS_DATA, 32'h0);
		check(q & m, REPLY & m);
	endtask
	// hang guard, far above the longest run
	always @(posedge hclk) begin
		cyc++;
		if (cyc == 60000) begin
			num_errors++;
			close_out;
		end
	end
	initial begin
		logic [7:0] rw [7] = '{spr_pkg::OFS_IMASK, spr_pkg::OFS_DMA, spr_pkg::OFS_RECEIVE_FRAME_COUNT_CNT,
			spr_pkg::OFS_DUMMY, spr_pkg::OFS_TXQ_CNT, spr_pkg::OFS_ITEST, spr_pkg::OFS_TDATA};
		logic [7:0] a;
		void'($urandom(32'hcdfa));
		// reset from time zero so the first edge already sees quiet outputs
		hresetn <= 1'b0;
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		// reset values of every readable word, plus the unmapped place at 0x40
		for (int i = 0; i <= 12; i++) begin
			a = 8'(4 * i);
			r = a == spr_pkg::OFS_STATUS ? spr_pkg::RST_STATUS : spr_pkg::RST_ZERO;
			if (a != spr_pkg::OFS_ICLEAR) rc(a, a == 8'h0 ? spr_pkg::RST_CTRL0 : r);
		end
		rc(spr_pkg::OFS_ITEST, 32'h0);
		rc(spr_pkg::OFS_TDATA, 32'h0);
		rc(8'h40, 32'h0);
		// random write and read back, then put back to rest
		foreach (rw[i]) begin
			r = $urandom();
			bus(1'b1, rw[i], r);
			rc(rw[i], r);
			bus(1'b1, rw[i], 32'h0);
		end
		r = {24'h0, 8'(2 * (1 + $urandom_range(126)))};
		bus(1'b1, spr_pkg::OFS_PRESCALE, r);
		rc(spr_pkg::OFS_PRESCALE, r);
		bus(1'b1, spr_pkg::OFS_STATUS, $urandom());
		rc(spr_pkg::OFS_STATUS, spr_pkg::RST_STATUS);
		bus(1'b1, spr_pkg::OFS_RAW, 32'hffffffff);
		rc(spr_pkg::OFS_RAW, 32'h0);
		bus(1'b1, spr_pkg::OFS_MASKED, 32'hffffffff);
		rc(spr_pkg::OFS_MASKED, 32'h0);
		bus(1'b1, spr_pkg::OFS_IMASK, 32'h1);
		bus(1'b1, spr_pkg::OFS_CTRL1, 32'h1 << spr_pkg::EN_BIT);
		// all four clock modes, shortest and longest frames first
		for (int i = 0; i < 10; i++) begin
			pol <= i[0];
			pha <= i[1];
			len <= i == 0 ? 6'h04 : i == 1 ? 6'h20 : 6'(4 + $urandom_range(28));
			@(posedge hclk);
			// half bit of six cycles or more outruns the three-flop input path
			frame(8'(12 + 2 * $urandom_range(2)), 8'($urandom_range(2)), $urandom());
		end
		// two dummy frames from the receive count
		r = $urandom();
		bus(1'b1, spr_pkg::OFS_ICLEAR, 32'h1);
		bus(1'b1, spr_pkg::OFS_DUMMY, r);
		bus(1'b1, spr_pkg::OFS_RECEIVE_FRAME_COUNT_CNT, 32'h2);
		wait_irq;
		bus(1'b1, spr_pkg::OFS_ICLEAR, 32'h1);
		repeat (2) @(posedge hclk);
		wait_irq;
		check({31'h0, irq}, 32'h1);
		check(got & (32'hffffffff >> (6'h20 - len)), r & (32'hffffffff >> (6'h20 - len)));
		rc(spr_pkg::OFS_RECEIVE_FRAME_COUNT_CNT, 32'h0);
		rc(spr_pkg::OFS_MASKED, 32'h1);
		// mask off, zero write ignored, one write clears
		bus(1'b1, spr_pkg::OFS_IMASK, 32'h0);
		rc(spr_pkg::OFS_MASKED, 32'h0);
		check({31'h0, irq}, 32'h0);
		bus(1'b1, spr_pkg::OFS_ICLEAR, 32'h0);
		rc(spr_pkg::OFS_RAW, 32'h1);
		bus(1'b1, spr_pkg::OFS_ICLEAR, 32'h1);
		rc(spr_pkg::OFS_RAW, 32'h0);
		// three-wire format rests low whatever the polarity bit says
		bus(1'b1, spr_pkg::OFS_CTRL0, 32'h00400043);
		repeat (2) @(posedge hclk);
		check({31'h0, sclk}, 32'h0);
		// second reset in mid-run puts written words back to rest
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		rc(spr_pkg::OFS_CTRL0, spr_pkg::RST_CTRL0);
		rc(spr_pkg::OFS_CTRL1, spr_pkg::RST_ZERO);
		close_out;
	end
endmodule
bind spr_ctrl spr_chk chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
	.htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
	.hreadyout(hreadyout), .hresp(hresp), .sclk(sclk), .mosi(mosi), .cs_n(cs_n), .irq(irq));
